// File: rtl/pdc_params.svh
// Purpose: Offsets, field positions, reset values and codes of the DMA engine
// Assumes: Included by the package and the engine
// Notes:   Definitions only
`ifndef PDC_PARAMS_SVH
`define PDC_PARAMS_SVH

// ============================================================
// Item size codes
`define PDC_SIZE_BYTE 2'h0
`define PDC_SIZE_HALF 2'h1
`define PDC_SIZE_WORD 2'h2

// ============================================================
// Mode word field positions
`define PDC_MODE_SIZE_LSB 0
`define PDC_MODE_SIZE_MSB 1
`define PDC_MODE_RING_BIT 2

// ============================================================
// Identity code layout: top bit gives direction, low bits the interface
`define PDC_PID_WIDTH 8
`define PDC_PID_DIR_BIT 7
`define PDC_PERIPH_BASE 32'h4000_0000
`define PDC_PERIPH_STRIDE 32'h0000_0100

// ============================================================
// Reset values
`define PDC_RST_WORD 32'h0000_0000
`define PDC_RST_COUNT 16'h0000
`define PDC_RST_PID 8'h00

`endif

// File: rtl/pdc_pkg.sv
// Purpose: Types of the peripheral DMA engine
// Assumes: pdc_params.svh supplies the codes
// Notes:   Types only
`include "pdc_params.svh"

package pdc_pkg;

  // ============================================================
  // Item size
  typedef enum logic [1:0] {
    PDC_BYTE = `PDC_SIZE_BYTE,
    PDC_HALF = `PDC_SIZE_HALF,
    PDC_WORD = `PDC_SIZE_WORD
  } pdc_size_t;

  // ============================================================
  // Transfer sequencer, Gray along idle, source, destination
  typedef enum logic [1:0] {
    PDC_IDLE = 2'h0,
    PDC_SRC = 2'h1,
    PDC_DST = 2'h3
  } pdc_state_t;

  typedef logic [`PDC_PID_WIDTH-1:0] pdc_pid_t;

endpackage

// File: rtl/pdc_peripheral_dma_engine.sv
// Purpose: Multi-channel peripheral DMA engine, one item moved at a time
// Assumes: Peripherals and memory share clk; channel config arrives as plain strobes
// Notes:   Overview of operation below
//
// Overview of operation
// - Each channel holds pointer, counter, both reloads and peripheral selection
// - Peripheral raises request; engine acknowledges when its item transfer starts
// - While clocks are held for sleep, everything freezes and later resumes
// - Identity code selects direction, handshake interface and holding register address
// - Pointer advances by 1, 2 or 4 after each finished item
// - Enabled channel starts at once after non-zero count or reload write
// - Counter counts items regardless of size, minus one per item
// - Pointer and counter are always visible live on outputs
// - Counter zero with non-zero reload copies both reloads into live registers
// - Without wraparound, both reload values clear right after each reload
// - Reload count write while counter zero loads counter and pointer directly
// - With wraparound set, reload values are kept and buffer repeats
// - Each channel has own item size: byte, halfword or word
// - Peripheral data bit n is register bit n; bits above item zeroed
// - Memory accesses use item size; misaligned pointer counts as access fault
// - On strobe enables, off strobe disables; enabled state is readable
// - Enabled channel serves requests while counter or reload is non-zero
// - Optional interrupt when a channel's buffers are all finished
// - Channels keep independent configuration and independent request service
// - Lowest numbered requesting channel is served first
// - Memory fault sets fault flag and stops channel until fault clear strobe
// - Reload-zero and finished flags shown per channel
`timescale 1ns/1ps
`default_nettype none
`include "pdc_params.svh"

module pdc_peripheral_dma_engine #(
  parameter int NUM_CH = 4,
  parameter int NUM_IF = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Sleep hold
  input wire logic sleep_hold,
  // Channel configuration strobes and data
  input wire logic [31:0] cfg_wdata,
  input wire logic [NUM_CH-1:0] cfg_wr_pointer,
  input wire logic [NUM_CH-1:0] cfg_wr_counter,
  input wire logic [NUM_CH-1:0] cfg_wr_pointer_reload,
  input wire logic [NUM_CH-1:0] cfg_wr_counter_reload,
  input wire logic [NUM_CH-1:0] cfg_wr_select,
  input wire logic [NUM_CH-1:0] cfg_wr_mode,
  input wire logic [NUM_CH-1:0] channel_on_strobe,
  input wire logic [NUM_CH-1:0] channel_off_strobe,
  input wire logic [NUM_CH-1:0] fault_clear_strobe,
  input wire logic [NUM_CH-1:0] irq_enable,
  // Channel state
  output logic [NUM_CH-1:0][31:0] memory_pointer,
  output logic [NUM_CH-1:0][15:0] item_counter,
  output logic [NUM_CH-1:0][31:0] pointer_reload_value,
  output logic [NUM_CH-1:0][15:0] counter_reload_value,
  output pdc_pkg::pdc_pid_t [NUM_CH-1:0] peripheral_select_reg,
  output pdc_pkg::pdc_size_t [NUM_CH-1:0] item_size_field,
  output logic [NUM_CH-1:0] wraparound_enable,
  output logic [NUM_CH-1:0] channel_enabled,
  output logic [NUM_CH-1:0] access_fault_flag,
  output logic [NUM_CH-1:0] reload_zero_flag,
  output logic [NUM_CH-1:0] finished_flag,
  output logic [NUM_CH-1:0] irq_req,
  // Peripheral handshake
  input wire logic [NUM_IF-1:0] periph_req,
  output logic [NUM_IF-1:0] periph_ack,
  // Peripheral register access
  output logic per_valid,
  output logic per_write,
  output logic [31:0] per_addr,
  output logic [31:0] per_wdata,
  input wire logic per_ready,
  input wire logic [31:0] per_rdata,
  // Memory master
  output logic mem_valid,
  output logic mem_write,
  output logic [31:0] mem_addr,
  output pdc_pkg::pdc_size_t mem_size,
  output logic [31:0] mem_wdata,
  input wire logic mem_ready,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_fault
);
  import pdc_pkg::*;

  localparam int CW = (NUM_CH > 1) ? $clog2(NUM_CH) : 1;
  localparam int IW = (NUM_IF > 1) ? $clog2(NUM_IF) : 1;

  // ============================================================
  // Parameter check
  if (NUM_CH < 1 || NUM_CH > 32 || NUM_IF < 1 || NUM_IF > (1 << (`PDC_PID_WIDTH - 1)))
  begin : g_bad_params
    $error("pdc_peripheral_dma_engine: unsupported channel or interface count");
  end

  // ============================================================
  // Helper functions
  function automatic logic [31:0] size_step(input pdc_size_t s);
    size_step = (s == PDC_BYTE) ? 32'h0000_0001 : (s == PDC_HALF) ? 32'h0000_0002 : 32'h0000_0004;
  endfunction

  function automatic logic [31:0] mask_item(input logic [31:0] d, input pdc_size_t s);
    mask_item = (s == PDC_BYTE) ? {24'h00_0000, d[7:0]} :
                (s == PDC_HALF) ? {16'h0000, d[15:0]} : d;
  endfunction

  function automatic logic misaligned(input logic [31:0] a, input pdc_size_t s);
    misaligned = (s == PDC_HALF) ? a[0] : (s == PDC_WORD) ? (a[1:0] != 2'h0) : 1'b0;
  endfunction

  function automatic logic [IW-1:0] pid_if(input pdc_pid_t p);
    pid_if = IW'(p[`PDC_PID_DIR_BIT-1:0] % NUM_IF);
  endfunction

  function automatic logic [31:0] pid_addr(input pdc_pid_t p);
    pid_addr = `PDC_PERIPH_BASE + `PDC_PERIPH_STRIDE * 32'(p[`PDC_PID_DIR_BIT-1:0]);
  endfunction

  function automatic pdc_size_t size_code(input logic [1:0] v);
    size_code = (v == `PDC_SIZE_BYTE) ? PDC_BYTE : (v == `PDC_SIZE_HALF) ? PDC_HALF : PDC_WORD;
  endfunction

  // ============================================================
  // Per-channel registers
  logic [NUM_CH-1:0][31:0] ptr_q;
  logic [NUM_CH-1:0][15:0] cnt_q;
  logic [NUM_CH-1:0][31:0] ptr_rl_q;
  logic [NUM_CH-1:0][15:0] cnt_rl_q;
  pdc_pid_t [NUM_CH-1:0] pid_q;
  pdc_size_t [NUM_CH-1:0] size_q;
  logic [NUM_CH-1:0] ring_q;
  logic [NUM_CH-1:0] en_q;
  logic [NUM_CH-1:0] fault_q;

  // ============================================================
  // Sequencer registers
  pdc_state_t state_q;
  logic [CW-1:0] cur_ch_q;
  logic cur_tx_q;
  pdc_size_t cur_size_q;
  logic [31:0] cur_mem_q;
  logic [31:0] cur_per_q;
  logic [31:0] data_q;

  // ============================================================
  // Arbitration
  logic [NUM_CH-1:0] ch_want;
  logic [NUM_CH-1:0] ch_req_live;
  logic [CW-1:0] grant_ch;
  logic grant;
  logic src_done;
  logic dst_done;
  logic item_done;
  logic item_fault;

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_want
    assign ch_req_live[c] = periph_req[pid_if(pid_q[c])];
    assign ch_want[c] = en_q[c] && !fault_q[c] && (cnt_q[c] != 16'h0000) && ch_req_live[c];
  end

  function automatic logic [CW-1:0] lowest(input logic [NUM_CH-1:0] v);
    lowest = '0;
    for (int i = NUM_CH - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        lowest = CW'(i);
      end
    end
  endfunction

  assign grant_ch = lowest(ch_want);
  assign grant = (state_q == PDC_IDLE) && (ch_want != '0) && !sleep_hold;

  // Source read: memory for transmit, peripheral for receive
  assign src_done = (state_q == PDC_SRC) && !sleep_hold && (cur_tx_q ? mem_ready : per_ready);
  assign dst_done = (state_q == PDC_DST) && !sleep_hold && (cur_tx_q ? per_ready : mem_ready);
  assign item_fault = !sleep_hold && (((state_q == PDC_SRC) && cur_tx_q && mem_ready && mem_fault) ||
                      ((state_q == PDC_DST) && !cur_tx_q && mem_ready && mem_fault));
  assign item_done = dst_done && !item_fault;

  // Acknowledge as the item transfer starts
  for (genvar k = 0; k < NUM_IF; k++)
  begin : g_ack
    assign periph_ack[k] = grant && (pid_if(pid_q[grant_ch]) == IW'(k));
  end

  // ============================================================
  // Sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      state_q <= PDC_IDLE;
      cur_ch_q <= '0;
      cur_tx_q <= 1'b0;
      cur_size_q <= PDC_BYTE;
      cur_mem_q <= `PDC_RST_WORD;
      cur_per_q <= `PDC_RST_WORD;
      data_q <= `PDC_RST_WORD;
    end
    else
    begin
      unique case (state_q)
        PDC_IDLE:
        begin
          if (grant)
          begin
            state_q <= PDC_SRC;
            cur_ch_q <= grant_ch;
            cur_tx_q <= pid_q[grant_ch][`PDC_PID_DIR_BIT];
            cur_size_q <= size_q[grant_ch];
            cur_mem_q <= ptr_q[grant_ch];
            cur_per_q <= pid_addr(pid_q[grant_ch]);
          end
        end
        PDC_SRC:
        begin
          if (item_fault || (src_done && !cur_tx_q && misaligned(cur_mem_q, cur_size_q)) ||
              (!sleep_hold && cur_tx_q && misaligned(cur_mem_q, cur_size_q)))
          begin
            state_q <= PDC_IDLE;
          end
          else if (src_done)
          begin
            state_q <= PDC_DST;
            data_q <= mask_item(cur_tx_q ? mem_rdata : per_rdata, cur_size_q);
          end
        end
        PDC_DST:
        begin
          if (dst_done || item_fault)
          begin
            state_q <= PDC_IDLE;
          end
        end
      endcase
    end
  end

  // ============================================================
  // Bus strobes
  logic tx_mis;
  assign tx_mis = (state_q == PDC_SRC) && cur_tx_q && misaligned(cur_mem_q, cur_size_q);
  assign mem_valid = !sleep_hold && !tx_mis && (((state_q == PDC_SRC) && cur_tx_q) ||
                     ((state_q == PDC_DST) && !cur_tx_q && !misaligned(cur_mem_q, cur_size_q)));
  assign mem_write = (state_q == PDC_DST);
  assign mem_addr = cur_mem_q;
  assign mem_size = cur_size_q;
  assign mem_wdata = data_q;
  assign per_valid = !sleep_hold && (((state_q == PDC_SRC) && !cur_tx_q) || ((state_q == PDC_DST) && cur_tx_q));
  assign per_write = (state_q == PDC_DST);
  assign per_addr = cur_per_q;
  assign per_wdata = data_q;

  // Misalignment detected before the memory phase counts as a fault
  logic [NUM_CH-1:0] fault_set;
  logic mis_hit;
  assign mis_hit = (!sleep_hold && tx_mis) ||
                   (src_done && !cur_tx_q && misaligned(cur_mem_q, cur_size_q));
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_fault
    assign fault_set[c] = (item_fault || mis_hit) && (cur_ch_q == CW'(c));
  end

  // ============================================================
  // Channel registers
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ptr_q <= '0;
      cnt_q <= '0;
      ptr_rl_q <= '0;
      cnt_rl_q <= '0;
      pid_q <= '0;
      size_q <= {NUM_CH{PDC_BYTE}};
      ring_q <= '0;
      en_q <= '0;
      fault_q <= '0;
    end
    else if (!sleep_hold)
    begin
      for (int c = 0; c < NUM_CH; c++)
      begin
        // Item completion
        if (item_done && cur_ch_q == CW'(c))
        begin
          ptr_q[c] <= ptr_q[c] + size_step(size_q[c]);
          cnt_q[c] <= cnt_q[c] - 16'h0001;
        end
        // Reload when counter is zero
        if (cnt_q[c] == 16'h0000 && cnt_rl_q[c] != 16'h0000 && !(state_q != PDC_IDLE && cur_ch_q == CW'(c)))
        begin
          ptr_q[c] <= ptr_rl_q[c];
          cnt_q[c] <= cnt_rl_q[c];
          if (!ring_q[c])
          begin
            ptr_rl_q[c] <= `PDC_RST_WORD;
            cnt_rl_q[c] <= `PDC_RST_COUNT;
          end
        end
        // Software writes win over hardware updates
        if (cfg_wr_pointer[c])
        begin
          ptr_q[c] <= cfg_wdata;
        end
        if (cfg_wr_counter[c])
        begin
          cnt_q[c] <= cfg_wdata[15:0];
        end
        if (cfg_wr_pointer_reload[c])
        begin
          ptr_rl_q[c] <= cfg_wdata;
        end
        if (cfg_wr_counter_reload[c])
        begin
          cnt_rl_q[c] <= cfg_wdata[15:0];
          if (cnt_q[c] == 16'h0000 && !cfg_wr_counter[c] && cfg_wdata[15:0] != 16'h0000)
          begin
            cnt_q[c] <= cfg_wdata[15:0];
            ptr_q[c] <= cfg_wr_pointer_reload[c] ? cfg_wdata : ptr_rl_q[c];
            if (!ring_q[c])
            begin
              cnt_rl_q[c] <= `PDC_RST_COUNT;
              ptr_rl_q[c] <= `PDC_RST_WORD;
            end
          end
        end
        if (cfg_wr_select[c])
        begin
          pid_q[c] <= cfg_wdata[`PDC_PID_WIDTH-1:0];
        end
        if (cfg_wr_mode[c])
        begin
          size_q[c] <= size_code(cfg_wdata[`PDC_MODE_SIZE_MSB:`PDC_MODE_SIZE_LSB]);
          ring_q[c] <= cfg_wdata[`PDC_MODE_RING_BIT];
        end
        // Enable and disable
        if (channel_off_strobe[c])
        begin
          en_q[c] <= 1'b0;
        end
        else if (channel_on_strobe[c])
        begin
          en_q[c] <= 1'b1;
        end
        // Fault flag, set wins over clear
        if (fault_set[c])
        begin
          fault_q[c] <= 1'b1;
        end
        else if (fault_clear_strobe[c])
        begin
          fault_q[c] <= 1'b0;
        end
      end
    end
  end

  // ============================================================
  // Visible state
  assign memory_pointer = ptr_q;
  assign item_counter = cnt_q;
  assign pointer_reload_value = ptr_rl_q;
  assign counter_reload_value = cnt_rl_q;
  assign peripheral_select_reg = pid_q;
  assign item_size_field = size_q;
  assign wraparound_enable = ring_q;
  assign channel_enabled = en_q;
  assign access_fault_flag = fault_q;

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_flags
    assign reload_zero_flag[c] = (cnt_rl_q[c] == 16'h0000);
    assign finished_flag[c] = (cnt_rl_q[c] == 16'h0000) && (cnt_q[c] == 16'h0000);
    assign irq_req[c] = irq_enable[c] && finished_flag[c];
  end

endmodule // pdc_peripheral_dma_engine
`default_nettype wire

// File: sim/pdc_dma_props.sv
// Purpose: Port assertions of the DMA engine
// Assumes: Bound to the engine top
// Notes:   Channel 0 stands for all channels
`timescale 1ns/1ps
`default_nettype none
module pdc_dma_props #(
  parameter int NUM_CH = 4,
  parameter int NUM_IF = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  input wire logic sleep_hold,
  // Channel control and state
  input wire logic [NUM_CH-1:0] channel_on_strobe,
  input wire logic [NUM_CH-1:0] channel_off_strobe,
  input wire logic [NUM_CH-1:0] irq_enable,
  input wire logic [NUM_CH-1:0][15:0] item_counter,
  input wire logic [NUM_CH-1:0][15:0] counter_reload_value,
  input wire logic [NUM_CH-1:0] channel_enabled,
  input wire logic [NUM_CH-1:0] finished_flag,
  input wire logic [NUM_CH-1:0] irq_req,
  // Handshake and buses
  input wire logic [NUM_IF-1:0] periph_req,
  input wire logic [NUM_IF-1:0] periph_ack,
  input wire logic per_valid,
  input wire logic mem_valid,
  input wire logic mem_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ==========================================
  // Assertions
  a_one_grant: assert property ($onehot0(periph_ack))
    else $error("two acknowledges");
  a_ack_needs_req: assert property ((periph_ack & ~periph_req) == '0)
    else $error("acknowledge without request");
  a_grant_spacing: assert property (|periph_ack |=> !(|periph_ack) [*2])
    else $error("grants too close");
  a_sleep_quiet: assert property (sleep_hold |-> !per_valid && !mem_valid && periph_ack == '0)
    else $error("activity while asleep");
  a_sleep_frozen: assert property (sleep_hold |=> $stable(item_counter))
    else $error("counter moved while asleep");
  a_mem_held: assert property (mem_valid && !mem_ready && !sleep_hold |=> mem_valid || sleep_hold)
    else $error("memory request dropped");
  a_finish_flag: assert property (finished_flag[0] == (item_counter[0] == 0 && counter_reload_value[0] == 0))
    else $error("finished flag wrong");
  a_irq_level: assert property (irq_req == (irq_enable & finished_flag))
    else $error("interrupt wrong");
  a_on_enables: assert property (channel_on_strobe[0] && !channel_off_strobe[0] && !sleep_hold
    |=> channel_enabled[0])
    else $error("channel not enabled");
  a_off_disables: assert property (channel_off_strobe[0] && !sleep_hold |=> !channel_enabled[0])
    else $error("channel not disabled");
  c_grant: cover property (|periph_ack);
  c_wake: cover property (sleep_hold ##1 !sleep_hold);
  c_mem_done: cover property (mem_valid && mem_ready);
endmodule // pdc_dma_props

bind pdc_peripheral_dma_engine pdc_dma_props #(.NUM_CH(NUM_CH), .NUM_IF(NUM_IF)) u_props (
  .clk(clk), .reset(reset), .sleep_hold(sleep_hold), .channel_on_strobe(channel_on_strobe),
  .channel_off_strobe(channel_off_strobe), .irq_enable(irq_enable), .item_counter(item_counter),
  .counter_reload_value(counter_reload_value), .channel_enabled(channel_enabled),
  .finished_flag(finished_flag), .irq_req(irq_req), .periph_req(periph_req), .periph_ack(periph_ack),
  .per_valid(per_valid), .mem_valid(mem_valid), .mem_ready(mem_ready));
`default_nettype wire

// File: sim/pdc_far_model.sv
// Purpose: Peripheral registers and memory facing the engine
// Assumes: Same clock as the engine
// Notes:   Data lines change every cycle while not answering
`timescale 1ns/1ps
`default_nettype none
module pdc_far_model (
  // Clock and pacing
  input wire logic clk,
  input wire logic [1:0] lat,
  // Peripheral registers
  input wire logic per_valid,
  output logic per_ready,
  output logic [31:0] per_rdata,
  // Memory
  input wire logic mem_valid,
  input wire logic [31:0] mem_addr,
  output logic mem_ready,
  output logic [31:0] mem_rdata,
  output logic mem_fault
);
  logic [1:0] pw_q = 2'h0;
  logic [1:0] mw_q = 2'h0;
  logic [31:0] pat_q = 32'h1357_9BDF;
  // ==========================================
  // Wait counters and data pattern
  always_ff @(posedge clk)
  begin
    pw_q <= (per_valid && !per_ready) ? pw_q + 2'h1 : 2'h0;
    mw_q <= (mem_valid && !mem_ready) ? mw_q + 2'h1 : 2'h0;
    pat_q <= {pat_q[30:0], pat_q[31] ^ pat_q[21] ^ pat_q[1] ^ pat_q[0]};
  end
  assign per_ready = per_valid && pw_q >= lat;
  assign per_rdata = per_ready ? pat_q : ~pat_q;
  assign mem_ready = mem_valid && mw_q >= lat;
  assign mem_rdata = mem_ready ? {pat_q[15:0], pat_q[31:16]} : pat_q;
  assign mem_fault = mem_ready && mem_addr[31:28] == 4'hF;
endmodule // pdc_far_model
`default_nettype wire

// File: sim/pdc_peripheral_dma_engine_test.sv
// Purpose: Self-checking bench of the DMA engine
// Assumes: Channel c uses handshake interface c
// Notes:   Even channels send, odd channels receive
`timescale 1ns/1ps
`default_nettype none
module pdc_peripheral_dma_engine_test;
  import pdc_pkg::*;
  localparam int NC = 4;
  logic clk = 1'b0, reset = 1'b1, sleep_hold = 1'b0;
  logic [31:0] cfg_wdata = '0, per_rdata, mem_rdata, per_addr, per_wdata, mem_addr, mem_wdata;
  logic [8:0][NC-1:0] st = '0;
  logic [NC-1:0] irq_enable = 4'h5, channel_enabled, access_fault_flag, finished_flag, irq_req, reload_zero_flag;
  logic [NC-1:0][31:0] memory_pointer, pointer_reload_value;
  logic [NC-1:0][15:0] item_counter, counter_reload_value;
  logic [7:0] periph_req = '0, periph_ack;
  logic per_valid, per_write, per_ready, mem_valid, mem_write, mem_ready, mem_fault;
  logic [1:0] lat = 2'h0;
  pdc_size_t mem_size;
  logic [31:0] rs = 32'h0000_004A, ep[NC] = '{default: '0}, erp[NC] = '{default: '0}, dq[$];
  int ec[NC], erc[NC], sz[NC], ac = 0, pc = -1, n_errors = 0, check_count = 0;
  bit en[NC], ring[NC], flt[NC], rq_rand = 0;

  pdc_peripheral_dma_engine #(.NUM_CH(NC), .NUM_IF(8)) dut (
    .clk(clk), .reset(reset), .sleep_hold(sleep_hold), .cfg_wdata(cfg_wdata),
    .cfg_wr_pointer(st[0]), .cfg_wr_counter(st[1]), .cfg_wr_pointer_reload(st[2]),
    .cfg_wr_counter_reload(st[3]), .cfg_wr_select(st[4]), .cfg_wr_mode(st[5]),
    .channel_on_strobe(st[6]), .channel_off_strobe(st[7]), .fault_clear_strobe(st[8]),
    .irq_enable(irq_enable), .memory_pointer(memory_pointer), .item_counter(item_counter),
    .pointer_reload_value(pointer_reload_value), .counter_reload_value(counter_reload_value),
    .peripheral_select_reg(), .item_size_field(), .wraparound_enable(), .channel_enabled(channel_enabled),
    .access_fault_flag(access_fault_flag), .reload_zero_flag(reload_zero_flag), .finished_flag(finished_flag),
    .irq_req(irq_req), .periph_req(periph_req), .periph_ack(periph_ack), .per_valid(per_valid),
    .per_write(per_write), .per_addr(per_addr), .per_wdata(per_wdata), .per_ready(per_ready),
    .per_rdata(per_rdata), .mem_valid(mem_valid), .mem_write(mem_write), .mem_addr(mem_addr),
    .mem_size(mem_size), .mem_wdata(mem_wdata), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
    .mem_fault(mem_fault));

  pdc_far_model far (.clk(clk), .lat(lat), .per_valid(per_valid), .per_ready(per_ready),
    .per_rdata(per_rdata), .mem_valid(mem_valid), .mem_addr(mem_addr), .mem_ready(mem_ready),
    .mem_rdata(mem_rdata), .mem_fault(mem_fault));

  initial forever #5 clk = ~clk;

  // ==========================================
  // Helpers
  function automatic logic [31:0] xs();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction

  function automatic logic [31:0] msk(logic [31:0] d, int s);
    return s == 0 ? d & 32'h0000_00FF : s == 1 ? d & 32'h0000_FFFF : d;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rld(input int c);
    if (ec[c] == 0 && erc[c] != 0)
    begin
      ep[c] = erp[c];
      ec[c] = erc[c];
      if (!ring[c]) erp[c] = '0;
      if (!ring[c]) erc[c] = 0;
    end
  endtask

  task automatic wr(input int k, input int c, input logic [31:0] v);
    @(posedge clk);
    #1;
    st[k][c] = 1'b1;
    cfg_wdata = v;
    @(posedge clk);
    #1;
    st[k][c] = 1'b0;
    if (k == 0) ep[c] = v;
    if (k == 1) ec[c] = int'(v[15:0]);
    if (k == 2) erp[c] = v;
    if (k == 3) erc[c] = int'(v[15:0]);
    if (k == 3) rld(c);
    if (k == 5) sz[c] = int'(v[1:0]);
    if (k == 5) ring[c] = v[2];
    if (k >= 6) en[c] = (k == 6) ? 1'b1 : (k == 7) ? 1'b0 : en[c];
    if (k == 8) flt[c] = 1'b0;
  endtask

  task automatic all_chk();
    #1;
    for (int c = 0; c < NC; c++)
    begin
      chk(32'(reload_zero_flag[c]), 32'(erc[c] == 0));
      chk(32'(irq_req[c]), 32'(irq_enable[c] && ec[c] == 0 && erc[c] == 0));
      chk(memory_pointer[c], ep[c]);
      chk(32'(item_counter[c]), 32'(ec[c]));
      chk(pointer_reload_value[c], erp[c]);
      chk(32'(counter_reload_value[c]), 32'(erc[c]));
      chk(32'(channel_enabled[c]), 32'(en[c]));
      chk(32'(access_fault_flag[c]), 32'(flt[c]));
      chk(32'(finished_flag[c]), 32'(ec[c] == 0 && erc[c] == 0));
    end
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================
  // Random pacing and requests
  always @(posedge clk)
  begin
    #1;
    lat = 2'(xs());
    if (rq_rand) periph_req = 8'(xs());
  end

  // ==========================================
  // Reference model at every result
  always @(posedge clk)
  begin
    if (!reset)
    begin
      if (pc >= 0) chk(memory_pointer[pc], ep[pc]);
      if (pc >= 0) chk(32'(item_counter[pc]), 32'(ec[pc]));
      if (|periph_ack)
      begin
        ac = -1;
        for (int c = NC - 1; c >= 0; c--)
          if (en[c] && !flt[c] && ec[c] != 0 && periph_req[c]) ac = c;
        chk(32'(periph_ack), 32'h1 << ac);
      end
      if (pc >= 0 && !sleep_hold) rld(pc);
      if (!sleep_hold) pc = -1;
      if (mem_valid && mem_ready) chk(mem_addr, ep[ac]);
      if (mem_valid && mem_ready) chk(32'(mem_size), 32'(sz[ac]));
      if (per_valid && per_ready) chk(per_addr, 32'h4000_0000 + 32'h100 * ac);
      if (mem_valid && mem_ready && mem_fault)
      begin
        flt[ac] = 1'b1;
        dq.delete();
      end
      else if ((mem_valid && mem_ready && !mem_write) || (per_valid && per_ready && !per_write))
        dq.push_back(msk(mem_valid ? mem_rdata : per_rdata, sz[ac]));
      else if ((mem_valid && mem_ready) || (per_valid && per_ready))
      begin
        chk(mem_valid ? mem_wdata : per_wdata, dq.pop_front());
        chk(32'(per_valid), 32'(ac % 2 == 0));
        ep[ac] += 32'(1 << sz[ac]);
        ec[ac]--;
        pc = ac;
      end
    end
  end

  initial
  begin
    #200000;
    n_errors++;
    complete_run();
  end

  // ==========================================
  // Scenarios
  initial
  begin
    repeat (3) @(posedge clk);
    #1;
    reset = 1'b0;
    all_chk();
    for (int c = 0; c < NC; c++)
    begin
      wr(4, c, {24'h0, c % 2 == 0, 7'(c)});
      wr(5, c, 32'(c % 3) | (c == 3 ? 32'h4 : 32'h0));
      wr(0, c, 32'h2000_0000 | (xs() & 32'h0000_FFF0));
      wr(2, c, 32'h3000_0000 + 32'h100 * c);
      wr(1, c, 2 + c);
      wr(3, c, 2);
      wr(6, c, 0);
    end
    rq_rand = 1;
    repeat (400) @(posedge clk);
    #1;
    sleep_hold = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    sleep_hold = 1'b0;
    repeat (300) @(posedge clk);
    wr(7, 3, 0);
    rq_rand = 0;
    periph_req = '0;
    repeat (20) @(posedge clk);
    all_chk();
    wr(2, 1, 32'h2400_0000);
    wr(3, 1, 5);
    all_chk();
    periph_req = 8'h02;
    #1;
    for (int i = 0; i < 6 && periph_ack[1] !== 1'b1; i++)
    begin
      @(posedge clk);
      #2;
    end
    chk(32'(periph_ack[1]), 32'h1);
    repeat (60) @(posedge clk);
    #1;
    wr(0, 2, 32'hF000_0000);
    wr(1, 2, 3);
    periph_req = 8'h04;
    repeat (20) @(posedge clk);
    all_chk();
    wr(0, 2, 32'h2800_0000);
    wr(8, 2, 0);
    repeat (40) @(posedge clk);
    #1;
    periph_req = '0;
    for (int c = 0; c < NC; c++)
      wr(7, c, 0);
    sleep_hold = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    sleep_hold = 1'b0;
    repeat (10) @(posedge clk);
    all_chk();
    complete_run();
  end
endmodule // pdc_peripheral_dma_engine_test
`default_nettype wire
